// File: core/nvm_cmd_pkg.sv
// shared constants, types and helpers of the loader erase and protection command handler
//
// Behaviour
// - erase carries 24-bit offset, MSB first, added to base 1100.0000 hex.
// - erase type 0 erases one page, 1 erases a whole sector.
// - page erase needs 128-byte alignment, sector erase needs 4 KB alignment.
// - any active read or write protection refuses every erase.
// - erase never touches configuration sector pages.
// - protection header holds 32-bit password MSB first, then options byte.
// - options bits 2:1 pick loader, code, data region; 11 and bits 7:3 reserved.
// - options bit 0 low clears protection, high installs it.
// - passwords 0000.0000 and 3FFF.FFFF hex are invalid.
// - command only updates stored password; hardware protection applies next startup.
// - set succeeds only without installed password, else error and password kept.
// - successful clear stores all ones as region password.
// - clear with wrong password erases all passwords and whole memory.
// - clearing the customer loader region password is refused with error.
// - clear without installed password skips the password check.
// - password compare ignores the protection-setting part of the word.
// - protection command is accepted whatever protection is active.
// - read and write/erase protection are independent per region.
package nvm_cmd_pkg;

  // ****************************************************************
  // header framing
  // ****************************************************************
  localparam logic [7:0] ERASE_LEN = 8'h05;
  localparam logic [7:0] ERASE_KIND = 8'h88;
  localparam logic [7:0] PROT_LEN = 8'h06;
  localparam logic [7:0] PROT_KIND = 8'h89;
  localparam logic [3:0] HDR_MAX = 4'h7;

  // ****************************************************************
  // memory layout
  // ****************************************************************
  localparam logic [31:0] NVM_BASE = 32'h1100_0000;
  localparam logic [23:0] NVM_SIZE = 24'h01_0000;
  localparam logic [11:0] CS_SECTOR = 12'h00f;
  localparam logic [7:0] ET_PAGE = 8'h00;
  localparam logic [7:0] ET_SECTOR = 8'h01;
  localparam logic [6:0] PAGE_MASK = 7'h7f;
  localparam logic [11:0] SECT_MASK = 12'hfff;

  // ****************************************************************
  // passwords and options
  // ****************************************************************
  localparam logic [31:0] PWD_MASK = 32'h3fff_ffff;
  localparam logic [31:0] PWD_BAD0 = 32'h0000_0000;
  localparam logic [31:0] PWD_BAD1 = 32'h3fff_ffff;
  localparam logic [31:0] PWD_CLEARED = 32'hffff_ffff;
  localparam logic [1:0] RGN_CUST = 2'b00;
  localparam logic [1:0] RGN_CODE = 2'b01;
  localparam logic [1:0] RGN_DATA = 2'b10;
  localparam logic [1:0] RGN_RSVD = 2'b11;
  localparam int OPT_OP = 0;
  localparam int OPT_SEL = 1;

  // ****************************************************************
  // result codes
  // ****************************************************************
  localparam logic [7:0] RC_SUCCESS = 8'h00;
  localparam logic [7:0] RC_READ_PROT = 8'h01;
  localparam logic [7:0] RC_ADDR_RANGE = 8'h02;
  localparam logic [7:0] RC_ERASE_PARAMS = 8'h03;
  localparam logic [7:0] RC_PAGE_ADDR = 8'h04;
  localparam logic [7:0] RC_SECT_ADDR = 8'h05;
  localparam logic [7:0] RC_SEG_INVALID = 8'h06;
  localparam logic [7:0] RC_PWD_INVALID = 8'h07;
  localparam logic [7:0] RC_NO_CUST_CLEAR = 8'h08;
  localparam logic [7:0] RC_PWD_EXISTS = 8'h09;
  localparam logic [7:0] RC_REMOVE_FAILED = 8'h0a;
  localparam logic [7:0] RC_ALL_ERASED = 8'h0b;
  localparam logic [7:0] RC_CMD_UNKNOWN = 8'h0c;
  localparam logic [7:0] RC_NVM_FAIL = 8'h0d;
  localparam logic [7:0] RC_HDR_INVALID = 8'h0e;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_PWD0 = 12'h008;
  localparam logic [11:0] ADDR_PWD1 = 12'h00c;
  localparam logic [11:0] ADDR_PWD2 = 12'h010;
  localparam int CTRL_RD_LSB = 0;
  localparam int CTRL_WR_LSB = 4;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0077;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int ST_BUSY = 0;
  localparam int ST_CODE_LSB = 8;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] len;
    logic [7:0] kind;
    logic [5:0][7:0] pl;
  } hdr_t;

  typedef struct packed {
    logic req;
    logic sector;
    logic [31:0] addr;
  } erase_t;

  typedef struct packed {
    logic req;
    logic [1:0] rgn;
    logic [31:0] data;
  } cswr_t;

  // protection bits sit in the top two bits and never take part
  function automatic logic pwd_valid(input logic [31:0] p);
    logic [31:0] m;
    m = p & PWD_MASK;
    return (m != PWD_BAD0) && (m != PWD_BAD1);
  endfunction : pwd_valid

  function automatic logic pwd_match(input logic [31:0] a, input logic [31:0] b);
    return (a & PWD_MASK) == (b & PWD_MASK);
  endfunction : pwd_match

endpackage : nvm_cmd_pkg

// File: core/hdr_collect.sv
// gathers header bytes from the loader link into one header word
`timescale 1ns/1ps
`default_nettype none
module hdr_collect
  import nvm_cmd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // byte stream
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  output logic byte_ready_o,
  // header out
  input wire logic busy_i,
  output logic hdr_valid_o,
  output hdr_t hdr_o
);

  typedef struct packed {
    logic got_len;
    logic [7:0] cnt;
    logic done;
    hdr_t hdr;
  } col_t;

  col_t s_r;
  col_t s_nxt;

  // stall while a command is being handled, so bytes wait at the source
  assign byte_ready_o = !s_r.done && !busy_i;
  assign hdr_valid_o = s_r.done;
  assign hdr_o = s_r.hdr;

  always_comb begin
    s_nxt = s_r;
    if (s_r.done) begin
      s_nxt.done = 1'b0;
      s_nxt.got_len = 1'b0;
    end else if (byte_valid_i && byte_ready_o) begin
      if (!s_r.got_len) begin
        s_nxt.hdr = '0;
        s_nxt.hdr.len = byte_i;
        s_nxt.cnt = 8'h00;
        s_nxt.got_len = (byte_i != 8'h00);
        s_nxt.done = (byte_i == 8'h00);
      end else begin
        // bytes past the payload area are counted but dropped
        if (s_r.cnt == 8'h00) begin
          s_nxt.hdr.kind = byte_i;
        end else if (s_r.cnt < 8'(HDR_MAX)) begin
          s_nxt.hdr.pl[3'(s_r.cnt - 8'h01)] = byte_i;
        end
        s_nxt.cnt = s_r.cnt + 8'h01;
        s_nxt.done = (s_r.cnt + 8'h01 == s_r.hdr.len);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : hdr_collect
`default_nettype wire

// File: core/apb_regs.sv
// apb slave: protection control, status and password readback
`timescale 1ns/1ps
`default_nettype none
module apb_regs
  import nvm_cmd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // block side
  input wire logic [31:0] status_i,
  input wire logic [2:0][31:0] pwd_i,
  output logic [31:0] ctrl_o
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic err;
  } apb_t;

  apb_t s_r;
  apb_t s_nxt;

  assign pready_o = 1'b1;
  assign pslverr_o = s_r.err && psel_i && penable_i;
  assign prdata_o = s_r.rdata;
  assign ctrl_o = s_r.ctrl;

  always_comb begin
    s_nxt = s_r;
    // answer is prepared in setup so the access phase needs no wait
    if (psel_i && !penable_i) begin
      s_nxt.err = 1'b0;
      s_nxt.rdata = 32'h0000_0000;
      case (paddr_i)
        ADDR_CTRL: s_nxt.rdata = s_r.ctrl;
        ADDR_STATUS: s_nxt.rdata = status_i;
        ADDR_PWD0: s_nxt.rdata = pwd_i[0];
        ADDR_PWD1: s_nxt.rdata = pwd_i[1];
        ADDR_PWD2: s_nxt.rdata = pwd_i[2];
        default: s_nxt.err = 1'b1;
      endcase
      if (pwrite_i && paddr_i != ADDR_CTRL) begin
        s_nxt.err = 1'b1;
      end
    end
    if (psel_i && penable_i && pwrite_i && !s_r.err) begin
      s_nxt.ctrl = pwdata_i & CTRL_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '{ctrl: CTRL_RST, rdata: 32'h0000_0000, err: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : apb_regs
`default_nettype wire

// File: core/nvm_erase_protect_command.sv
// loader command handler for memory erase and region password set or clear
`timescale 1ns/1ps
`default_nettype none
module nvm_erase_protect_command
  import nvm_cmd_pkg::*;
(
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  // apb register bus
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // header bytes from the link framing layer
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_DATA_I,
  output logic RX_READY_O,
  // response to the framing layer
  output logic RSP_VALID_O,
  output logic [7:0] RSP_CODE_O,
  // memory controller
  output logic ERASE_REQ_O,
  output logic ERASE_SECTOR_O,
  output logic [31:0] ERASE_ADDR_O,
  output logic MASS_ERASE_O,
  output logic CS_WRITE_O,
  output logic [1:0] CS_REGION_O,
  output logic [31:0] CS_DATA_O,
  input wire logic NVM_DONE_I,
  input wire logic NVM_FAIL_I
);

  // ****************************************************************
  // types and state
  // ****************************************************************
  // one command in flight at a time
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHECK,
    ST_ERASE,
    ST_CSWR,
    ST_MASS,
    ST_RESP
  } st_t;

  typedef struct packed {
    st_t st;
    hdr_t hdr;
    logic [2:0][31:0] pwd;
    logic [7:0] code;
    logic rsp_v;
    logic clear_op;
    erase_t erase;
    cswr_t cswr;
    logic mass;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // ****************************************************************
  // sub blocks
  // ****************************************************************
  logic hdr_valid;
  hdr_t hdr;

  logic [31:0] ctrl;
  logic [31:0] status;
  logic busy;

  assign busy = (s_r.st != ST_IDLE);

  // header copied once, in the idle state
  hdr_collect u_collect (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .byte_valid_i(RX_VALID_I),
    .byte_i(RX_DATA_I),
    .byte_ready_o(RX_READY_O),
    .busy_i(busy),
    .hdr_valid_o(hdr_valid),
    .hdr_o(hdr)
  );

  // busy and the last result for polling
  always_comb begin
    status = 32'h0000_0000;
    status[ST_BUSY] = busy;
    status[ST_CODE_LSB +: 8] = s_r.code;
  end

  // ctrl stands in for boot-time protection
  apb_regs u_regs (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .psel_i(PSEL_I),
    .penable_i(PENABLE_I),
    .pwrite_i(PWRITE_I),
    .paddr_i(PADDR_I),
    .pwdata_i(PWDATA_I),
    .prdata_o(PRDATA_O),
    .pready_o(PREADY_O),
    .pslverr_o(PSLVERR_O),
    .status_i(status),
    .pwd_i(s_r.pwd),
    .ctrl_o(ctrl)
  );

  // ****************************************************************
  // header fields
  // ****************************************************************
  logic [2:0] rd_prot;
  logic [2:0] wr_prot;

  logic [23:0] offset;
  logic [7:0] etype;

  logic [31:0] sup_pwd;
  logic [7:0] opts;
  logic [1:0] rgn;
  logic set_op;

  // protection bits come from startup, independent per region
  assign rd_prot = ctrl[CTRL_RD_LSB +: 3];
  assign wr_prot = ctrl[CTRL_WR_LSB +: 3];

  // erase view of the payload
  assign offset = {s_r.hdr.pl[0], s_r.hdr.pl[1], s_r.hdr.pl[2]};
  assign etype = s_r.hdr.pl[3];

  // protection view of the same bytes
  assign sup_pwd = {s_r.hdr.pl[0], s_r.hdr.pl[1], s_r.hdr.pl[2], s_r.hdr.pl[3]};
  assign opts = s_r.hdr.pl[4];
  assign rgn = opts[OPT_SEL +: 2];
  assign set_op = opts[OPT_OP];

  // ****************************************************************
  // erase checks
  // ****************************************************************
  logic [7:0] erase_code;
  logic erase_ok;

  always_comb begin
    erase_code = RC_SUCCESS;
    erase_ok = 1'b0;

    // first failing check picks the code
    if (rd_prot != 3'b000) begin
      erase_code = RC_READ_PROT;
    end else if (wr_prot != 3'b000) begin
      erase_code = RC_ERASE_PARAMS;
    end else if (etype != ET_PAGE && etype != ET_SECTOR) begin
      erase_code = RC_ERASE_PARAMS;
    end else if (offset >= NVM_SIZE) begin
      erase_code = RC_ADDR_RANGE;
    end else if (etype == ET_PAGE && (offset[6:0] & PAGE_MASK) != 7'h00) begin
      erase_code = RC_PAGE_ADDR;
    end else if (etype == ET_SECTOR && (offset[11:0] & SECT_MASK) != 12'h000) begin
      erase_code = RC_SECT_ADDR;
    end else if (offset[23:12] == CS_SECTOR) begin
      // config sector stays untouched whatever granularity is asked
      erase_code = RC_ADDR_RANGE;
    end else begin
      erase_ok = 1'b1;
    end
  end

  // ****************************************************************
  // protection checks
  // ****************************************************************
  logic [31:0] cur_pwd;
  logic installed;

  logic [7:0] prot_code;
  logic prot_store;
  logic prot_mass;

  // reserved selector never indexes the array
  assign cur_pwd = (rgn == RGN_RSVD) ? PWD_CLEARED : s_r.pwd[rgn];
  assign installed = pwd_valid(cur_pwd);

  // active hardware protection deliberately plays no part here
  always_comb begin
    prot_code = RC_SUCCESS;
    prot_store = 1'b0;
    prot_mass = 1'b0;

    if (rgn == RGN_RSVD) begin
      prot_code = RC_SEG_INVALID;
    end else if (set_op) begin
      if (installed) begin
        prot_code = RC_PWD_EXISTS;
      end else if (!pwd_valid(sup_pwd)) begin
        prot_code = RC_PWD_INVALID;
      end else begin
        prot_store = 1'b1;
      end
    end else begin
      if (rgn == RGN_CUST) begin
        prot_code = RC_NO_CUST_CLEAR;
      end else if (!installed) begin
        prot_store = 1'b1;
      end else if (pwd_match(sup_pwd, cur_pwd)) begin
        prot_store = 1'b1;
      end else begin
        // wrong guess wipes all passwords and memory
        prot_mass = 1'b1;
      end
    end
  end

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp_v = 1'b0;

    case (s_r.st)
      ST_IDLE: begin
        if (hdr_valid) begin
          s_nxt.hdr = hdr;
          s_nxt.st = ST_CHECK;
        end
      end

      ST_CHECK: begin
        s_nxt.st = ST_RESP;
        if (s_r.hdr.kind == ERASE_KIND) begin
          if (s_r.hdr.len != ERASE_LEN) begin
            s_nxt.code = RC_HDR_INVALID;
          end else if (erase_ok) begin
            s_nxt.erase.req = 1'b1;
            s_nxt.erase.sector = (etype == ET_SECTOR);
            s_nxt.erase.addr = NVM_BASE + {8'h00, offset};
            s_nxt.st = ST_ERASE;
          end else begin
            s_nxt.code = erase_code;
          end
        end else if (s_r.hdr.kind == PROT_KIND) begin
          if (s_r.hdr.len != PROT_LEN) begin
            s_nxt.code = RC_HDR_INVALID;
          end else if (prot_store) begin
            // only the stored image changes; hardware picks it up at boot
            s_nxt.cswr.req = 1'b1;
            s_nxt.cswr.rgn = rgn;
            s_nxt.cswr.data = set_op ? sup_pwd : PWD_CLEARED;
            s_nxt.clear_op = !set_op;
            s_nxt.st = ST_CSWR;
          end else if (prot_mass) begin
            s_nxt.mass = 1'b1;
            s_nxt.st = ST_MASS;
          end else begin
            s_nxt.code = prot_code;
          end
        end else begin
          s_nxt.code = RC_CMD_UNKNOWN;
        end
      end

      ST_ERASE: begin
        // request held until the controller answers
        if (NVM_DONE_I) begin
          s_nxt.erase.req = 1'b0;
          s_nxt.code = NVM_FAIL_I ? RC_NVM_FAIL : RC_SUCCESS;
          s_nxt.st = ST_RESP;
        end
      end

      ST_CSWR: begin
        if (NVM_DONE_I) begin
          s_nxt.cswr.req = 1'b0;
          if (NVM_FAIL_I) begin
            s_nxt.code = s_r.clear_op ? RC_REMOVE_FAILED : RC_NVM_FAIL;
          end else begin
            s_nxt.pwd[s_r.cswr.rgn] = s_r.cswr.data;
            s_nxt.code = RC_SUCCESS;
          end
          s_nxt.st = ST_RESP;
        end
      end

      ST_MASS: begin
        if (NVM_DONE_I) begin
          s_nxt.mass = 1'b0;
          if (NVM_FAIL_I) begin
            s_nxt.code = RC_NVM_FAIL;
          end else begin
            // every region loses its password, not just the selected one
            s_nxt.pwd = {3{PWD_CLEARED}};
            s_nxt.code = RC_ALL_ERASED;
          end
          s_nxt.st = ST_RESP;
        end
      end

      ST_RESP: begin
        // code stands until the next result
        s_nxt.rsp_v = 1'b1;
        s_nxt.st = ST_IDLE;
      end

      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  // passwords reset to none installed
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.pwd <= {3{PWD_CLEARED}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // outputs come straight from state
  assign RSP_VALID_O = s_r.rsp_v;
  assign RSP_CODE_O = s_r.code;

  assign ERASE_REQ_O = s_r.erase.req;
  assign ERASE_SECTOR_O = s_r.erase.sector;
  assign ERASE_ADDR_O = s_r.erase.addr;

  assign MASS_ERASE_O = s_r.mass;

  assign CS_WRITE_O = s_r.cswr.req;
  assign CS_REGION_O = s_r.cswr.rgn;
  assign CS_DATA_O = s_r.cswr.data;

endmodule : nvm_erase_protect_command
`default_nettype wire

// File: testbench/nvm_erase_protect_command_props.sv
// concurrent checks on the memory request and response ports of the command handler
`timescale 1ns/1ps
`default_nettype none
module nvm_cmd_props
  import nvm_cmd_pkg::*;
(
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  // observed ports
  input wire logic RSP_VALID_O,
  input wire logic ERASE_REQ_O,
  input wire logic ERASE_SECTOR_O,
  input wire logic [31:0] ERASE_ADDR_O,
  input wire logic MASS_ERASE_O,
  input wire logic CS_WRITE_O,
  input wire logic [1:0] CS_REGION_O,
  input wire logic [31:0] CS_DATA_O,
  input wire logic NVM_DONE_I
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);
  // ****
  // erase requests
  // ****
  a_erase_base: assert property (ERASE_REQ_O |-> ERASE_ADDR_O[31:16] == 16'h1100)
    else $error("erase address outside memory");
  a_page_align: assert property (ERASE_REQ_O && !ERASE_SECTOR_O |-> ERASE_ADDR_O[6:0] == 7'h00)
    else $error("page erase misaligned");
  a_sect_align: assert property (ERASE_REQ_O && ERASE_SECTOR_O |-> ERASE_ADDR_O[11:0] == 12'h000)
    else $error("sector erase misaligned");
  a_no_config: assert property (ERASE_REQ_O |-> ERASE_ADDR_O[15:12] != 4'hf)
    else $error("erase hits config sector");
  a_req_held: assert property (ERASE_REQ_O && !NVM_DONE_I |=> ERASE_REQ_O && $stable(ERASE_ADDR_O)
    && $stable(ERASE_SECTOR_O))
    else $error("erase request dropped early");
  a_done_rsp: assert property (ERASE_REQ_O && NVM_DONE_I |-> ##2 RSP_VALID_O)
    else $error("no response after erase");
  a_rsp_pulse: assert property (RSP_VALID_O |=> !RSP_VALID_O)
    else $error("response longer than one cycle");
  // ****
  // password store
  // ****
  a_pwd_valid: assert property (CS_WRITE_O |-> CS_DATA_O == 32'hffff_ffff ||
    ((CS_DATA_O & 32'h3fff_ffff) != 32'h0 && (CS_DATA_O & 32'h3fff_ffff) != 32'h3fff_ffff))
    else $error("invalid password stored");
  a_rgn_legal: assert property (CS_WRITE_O |-> CS_REGION_O != 2'b11)
    else $error("reserved region written");
  a_mass_alone: assert property (MASS_ERASE_O |-> !ERASE_REQ_O && !CS_WRITE_O)
    else $error("mass erase overlaps another request");
  c_page: cover property (ERASE_REQ_O && !ERASE_SECTOR_O);
  c_sect: cover property (ERASE_REQ_O && ERASE_SECTOR_O);
  c_mass: cover property (MASS_ERASE_O);
endmodule : nvm_cmd_props

bind nvm_erase_protect_command nvm_cmd_props nvm_cmd_props_inst (.CLOCK_I, .RESET_I, .RSP_VALID_O,
  .ERASE_REQ_O, .ERASE_SECTOR_O, .ERASE_ADDR_O, .MASS_ERASE_O, .CS_WRITE_O, .CS_REGION_O, .CS_DATA_O,
  .NVM_DONE_I);
`default_nettype wire

// File: testbench/nvm_ctrl_model.sv
// memory controller stand-in answering each request after a chosen latency
`timescale 1ns/1ps
`default_nettype none
module nvm_ctrl_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // request and behaviour
  input wire logic busy_i,
  input wire logic [3:0] lat_i,
  input wire logic fail_i,
  // answer
  output logic done_o,
  output logic fail_o
);
  logic [3:0] cnt_r;
  // ****
  // answer timing
  // ****
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 4'h0;
      done_o <= 1'b0;
      fail_o <= 1'b0;
    end else if (busy_i && !done_o && cnt_r >= lat_i) begin
      cnt_r <= 4'h0;
      done_o <= 1'b1;
      fail_o <= fail_i;
    end else begin
      cnt_r <= (busy_i && !done_o) ? cnt_r + 4'h1 : 4'h0;
      done_o <= 1'b0;
      // fail is meaningless outside done, so it shows the opposite
      fail_o <= ~fail_i;
    end
  end
endmodule : nvm_ctrl_model
`default_nettype wire

// File: testbench/nvm_erase_protect_command_test.sv
// self-checking bench for the erase and protection command handler
`timescale 1ns/1ps
`default_nettype none
module nvm_erase_protect_command_test
  import nvm_cmd_pkg::*;
;
  logic CLOCK_I, RESET_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O;
  logic [11:0] PADDR_I;
  logic [31:0] PWDATA_I, PRDATA_O, ERASE_ADDR_O, CS_DATA_O, seen_a, q;
  logic RX_VALID_I, RX_READY_O, RSP_VALID_O, ERASE_REQ_O, ERASE_SECTOR_O, MASS_ERASE_O, CS_WRITE_O;
  logic [7:0] RX_DATA_I, RSP_CODE_O;
  logic [1:0] CS_REGION_O;
  logic NVM_DONE_I, NVM_FAIL_I, fmode, seen_s, mass_seen, e;
  logic [3:0] lat_r;
  int errors, total_checks;

  nvm_erase_protect_command nvm_erase_protect_command_inst (.CLOCK_I, .RESET_I, .PSEL_I, .PENABLE_I,
    .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .RX_VALID_I, .RX_DATA_I,
    .RX_READY_O, .RSP_VALID_O, .RSP_CODE_O, .ERASE_REQ_O, .ERASE_SECTOR_O, .ERASE_ADDR_O,
    .MASS_ERASE_O, .CS_WRITE_O, .CS_REGION_O, .CS_DATA_O, .NVM_DONE_I, .NVM_FAIL_I);
  nvm_ctrl_model nvm_ctrl_model_inst (.clk_i(CLOCK_I), .rst_i(RESET_I),
    .busy_i(ERASE_REQ_O | MASS_ERASE_O | CS_WRITE_O), .lat_i(lat_r), .fail_i(fmode),
    .done_o(NVM_DONE_I), .fail_o(NVM_FAIL_I));

  always #12.5 CLOCK_I = ~CLOCK_I;
  always @(posedge CLOCK_I) begin
    if (ERASE_REQ_O === 1'b1) begin
      seen_a = ERASE_ADDR_O;
      seen_s = ERASE_SECTOR_O;
    end
    if (MASS_ERASE_O === 1'b1) mass_seen = 1'b1;
  end

  // ****
  // shared tasks
  // ****
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  task automatic stall();
    errors++;
    $display("Error at %0t: wait ran out", $time);
    wrap_up();
  endtask : stall

  task automatic check(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge CLOCK_I);
    PENABLE_I <= 1'b1;
    n = 0;
    do begin @(posedge CLOCK_I); n++; end while (PREADY_O !== 1'b1 && n < 50);
    if (n == 50) stall();
    q = PRDATA_O;
    e = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    PWDATA_I <= ~d;
    @(posedge CLOCK_I);
  endtask : apb

  task automatic send(input logic [55:0] h, input int n, input logic [7:0] x);
    int k;
    for (int i = 0; i < n; i++) begin
      RX_VALID_I <= 1'b1;
      RX_DATA_I <= h[55-8*i -: 8];
      k = 0;
      do begin @(posedge CLOCK_I); k++; end while (RX_READY_O !== 1'b1 && k < 100);
      if (k == 100) stall();
    end
    RX_VALID_I <= 1'b0;
    RX_DATA_I <= ~RX_DATA_I;
    k = 0;
    do begin @(posedge CLOCK_I); k++; end while (RSP_VALID_O !== 1'b1 && k < 300);
    if (k == 300) stall();
    check(32'(RSP_CODE_O), 32'(x));
  endtask : send

  task automatic erase(input logic [23:0] o, input logic [7:0] t, input logic [7:0] x);
    send({8'h05, 8'h88, o, t, 8'h00}, 6, x);
  endtask : erase

  task automatic prot(input logic [31:0] p, input logic [7:0] o, input logic [7:0] x);
    send({8'h06, 8'h89, p, o}, 7, x);
  endtask : prot

  // ****
  // scenarios
  // ****
  task automatic t_regs();
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(q, 32'h0);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, ADDR_PWD0 + 12'(4 * i), 32'h0);
      check(q, 32'hffff_ffff);
    end
    apb(1'b0, 12'h020, 32'h0);
    check(32'(e), 32'h1);
    apb(1'b1, ADDR_STATUS, 32'h1);
    check(32'(e), 32'h1);
  endtask : t_regs

  task automatic t_erase();
    logic [23:0] off [8] = '{24'h000080, 24'h000081, 24'h001000, 24'h001080,
      24'h002000, 24'h00f000, 24'h00f080, 24'h010000};
    logic [7:0] et [8] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h02, 8'h01, 8'h00, 8'h01};
    logic [7:0] rc [8] = '{RC_SUCCESS, RC_PAGE_ADDR, RC_SUCCESS, RC_SECT_ADDR,
      RC_ERASE_PARAMS, RC_ADDR_RANGE, RC_ADDR_RANGE, RC_ADDR_RANGE};
    for (int i = 0; i < 8; i++) begin
      lat_r <= 4'(i);
      seen_a = 32'h0;
      erase(off[i], et[i], rc[i]);
      check(seen_a, rc[i] == RC_SUCCESS ? 32'h1100_0000 + {8'h00, off[i]} : 32'h0);
      if (rc[i] == RC_SUCCESS) check(32'(seen_s), 32'(et[i][0]));
    end
  endtask : t_erase

  task automatic t_guard();
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    erase(24'h000100, 8'h00, RC_READ_PROT);
    apb(1'b1, ADDR_CTRL, 32'h0000_0040);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(q, 32'h0000_0040);
    erase(24'h000100, 8'h00, RC_ERASE_PARAMS);
    apb(1'b1, ADDR_CTRL, 32'h0);
    fmode <= 1'b1;
    erase(24'h000200, 8'h00, RC_NVM_FAIL);
    fmode <= 1'b0;
    send({8'h05, 8'h87, 32'h0, 8'h00}, 6, RC_CMD_UNKNOWN);
    send({8'h06, 8'h88, 40'h0}, 7, RC_HDR_INVALID);
    send({8'h05, 8'h89, 40'h0}, 6, RC_HDR_INVALID);
  endtask : t_guard

  task automatic t_prot();
    apb(1'b1, ADDR_CTRL, 32'h0000_0077);
    prot(32'h1234_5678, 8'h03, RC_SUCCESS);
    apb(1'b0, ADDR_PWD1, 32'h0);
    check(q, 32'h1234_5678);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(q, 32'h0000_0077);
    prot(32'h0bad_0bad, 8'h03, RC_PWD_EXISTS);
    apb(1'b0, ADDR_PWD1, 32'h0);
    check(q, 32'h1234_5678);
    prot(32'h3fff_ffff, 8'h05, RC_PWD_INVALID);
    prot(32'hc000_0000, 8'h05, RC_PWD_INVALID);
    prot(32'h1111_1111, 8'h07, RC_SEG_INVALID);
    prot(32'h1111_1111, 8'h00, RC_NO_CUST_CLEAR);
    prot(32'h9234_5678, 8'hfa, RC_SUCCESS);
    apb(1'b0, ADDR_PWD1, 32'h0);
    check(q, 32'hffff_ffff);
    prot(32'h0, 8'h04, RC_SUCCESS);
    prot(32'h0000_1111, 8'h05, RC_SUCCESS);
    mass_seen = 1'b0;
    prot(32'h0000_2222, 8'h04, RC_ALL_ERASED);
    check(32'(mass_seen), 32'h1);
    apb(1'b0, ADDR_PWD2, 32'h0);
    check(q, 32'hffff_ffff);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(q, {16'h0000, RC_ALL_ERASED, 8'h00});
    fmode <= 1'b1;
    prot(32'h0, 8'h04, RC_REMOVE_FAILED);
    fmode <= 1'b0;
  endtask : t_prot

  initial begin
    CLOCK_I = 1'b0;
    RESET_I = 1'b1;
    {PSEL_I, PENABLE_I, PWRITE_I, RX_VALID_I, fmode, mass_seen, seen_s} = '0;
    PADDR_I = 12'h000;
    PWDATA_I = 32'h0;
    RX_DATA_I = 8'h00;
    lat_r = 4'h2;
    seen_a = 32'h0;
    repeat (16) @(posedge CLOCK_I);
    RESET_I <= 1'b0;
    t_regs();
    t_erase();
    t_guard();
    t_prot();
    wrap_up();
  end
endmodule : nvm_erase_protect_command_test
`default_nettype wire
